// File: lsi_top.sv
// latched status registers and open-drain interrupt of one framer path
`include "lsi_params.svh"
// Summary of operation
// - every status and info bit latches to 1 when its event or alarm occurs
// - a latched bit holds until read, read clears it, sets again on new event
// - alarm bits stay set across a read while the alarm is still present
// - a write refreshes the readable copy only where the written bit is 1
// - only primary, secondary, datalink and bert sources reach the interrupt
// - each interrupt source has its own mask bit; masked sources stay silent
// - unmasked primary alarms interrupt on both rising and falling change
// - alarm interrupt releases once its bit is read, even if alarm persists
// - unmasked event interrupts on occurrence and releases when its bit is read
// - summary shows pending requests: bert, path b and path a sources
// - unassigned summary and info positions carry no meaning for the host
// - alignment change flag sets when a resync lands on a new alignment
// - eight zero flag sets on any run of eight or more zeros
// - sixteen zero flag sets on any run of sixteen or more zeros
// - severe framing flag sets on two framing errors in any six
// - substitution codeword flag sets on a codeword whatever the line coding
// - framing bit error flag sets on each errored framing bit
module lsi_top #(
    parameter int ZERO_SHORT = `LSI_ZERO8_RUN,
    parameter int ZERO_LONG  = `LSI_ZERO16_RUN,
    parameter int SEF_WIN    = `LSI_SEF_WINDOW,
    parameter int SEF_ERRS   = `LSI_SEF_LIMIT
) (
    // clock and reset
    input wire logic               CLK,
    input wire logic               RSTN,
    // parallel control port
    input wire logic [7:0]         ADDR,
    input wire lsi_pkg::lsi_byte_t WDATA,
    input wire logic               WR_STB,
    input wire logic               RD_STB,
    output lsi_pkg::lsi_byte_t     RDATA,
    // alarm levels and event pulses of the path
    input wire logic [4:0]         PRI_ALARM,
    input wire logic [2:0]         PRI_EVENT,
    input wire lsi_pkg::lsi_byte_t SEC_EVENT,
    input wire lsi_pkg::lsi_byte_t RX2_EVENT,
    input wire lsi_pkg::lsi_byte_t RX3_EVENT,
    input wire logic               RX3_CARRIER_LOSS,
    // receive line and framer
    input wire logic               RX_BIT_STB,
    input wire logic               RX_LINE_POS_IN,
    input wire logic               RX_LINE_NEG_IN,
    input wire logic               FBIT_STB,
    input wire logic               FBIT_ERR_IN,
    input wire logic               RESYNC_DONE,
    input wire lsi_pkg::lsi_byte_t ALIGN_POS,
    // requests of neighbouring blocks, already masked there
    input wire logic               PATH_A_DATALINK_REQUEST,
    input wire logic               PATH_B_PRIMARY_REQUEST,
    input wire logic               PATH_B_SECONDARY_REQUEST,
    input wire logic               PATH_B_DATALINK_REQUEST,
    input wire logic               BERT_REQUEST,
    // open-drain interrupt pin
    output logic                   INT_OUT,
    output logic                   INT_OE_N
);
    import lsi_pkg::*;

    localparam int NREG = 5;
    localparam lsi_byte_t SEF_MASK = lsi_byte_t'((1 << SEF_WIN) - 1);
    localparam lsi_byte_t ALARMS [NREG] = '{
        `LSI_ALARM_PRI,
        `LSI_ALARM_NONE,
        `LSI_ALARM_NONE,
        `LSI_ALARM_NONE,
        lsi_byte_t'(1 << `LSI_RX3_CARRIER)
    };

    // refuse figures that the counters cannot hold
    if (ZERO_SHORT < 1 || ZERO_LONG <= ZERO_SHORT || ZERO_LONG > 31) begin : g_bad_zero
        $error("zero run lengths out of range");
    end
    if (SEF_WIN < 2 || SEF_WIN > 8 || SEF_ERRS < 1 || SEF_ERRS > SEF_WIN) begin : g_bad_sef
        $error("severe framing window out of range");
    end

    logic [1:0] rst_sync;
    logic       rst_n;
    lsi_top_s   st;
    lsi_top_s   next_st;
    lsi_byte_t  set_v   [NREG];
    lsi_byte_t  level_v [NREG];
    lsi_byte_t  shown_v [NREG];
    lsi_byte_t  pend_v  [NREG];
    logic [NREG-1:0] sel;
    lsi_byte_t  rx1_set;
    lsi_byte_t  sum;
    lsi_byte_t  new_pos;
    lsi_byte_t  new_neg;
    lsi_byte_t  new_hist;
    logic [5:0] run_len;
    logic       zero_in;
    logic       cw_hit;

    // reset release through two flops; assertion is immediate
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // address decode of the latched registers
    assign sel[REG_PRI] = (ADDR == `LSI_ADR_PRI_STAT);
    assign sel[REG_SEC] = (ADDR == `LSI_ADR_SEC_STAT);
    assign sel[REG_RX1] = (ADDR == `LSI_ADR_RX_ONE);
    assign sel[REG_RX2] = (ADDR == `LSI_ADR_RX_TWO);
    assign sel[REG_RX3] = (ADDR == `LSI_ADR_RX_THREE);

    // sources of each register; unassigned positions are never set
    assign set_v[REG_PRI]   = {PRI_EVENT, 5'h00};
    assign level_v[REG_PRI] = {3'h0, PRI_ALARM};
    assign set_v[REG_SEC]   = SEC_EVENT;
    assign level_v[REG_SEC] = 8'h00;
    assign set_v[REG_RX1]   = rx1_set;
    assign level_v[REG_RX1] = 8'h00;
    assign set_v[REG_RX2]   = RX2_EVENT;
    assign level_v[REG_RX2] = 8'h00;
    assign set_v[REG_RX3]   = RX3_EVENT & ~ALARMS[REG_RX3];
    assign level_v[REG_RX3] = lsi_byte_t'(RX3_CARRIER_LOSS) << `LSI_RX3_CARRIER;

    // one latched register per status source
    for (genvar g = 0; g < NREG; g++) begin : g_stat
        lsi_stat_if bus();
        assign bus.set    = set_v[g];
        assign bus.level  = level_v[g];
        assign bus.wr     = WR_STB && sel[g];
        assign bus.rd     = RD_STB && sel[g];
        assign bus.wdata  = WDATA;
        assign shown_v[g] = bus.shown;
        assign pend_v[g]  = bus.pend;
        lsi_latch_reg #(
            .ALARM (ALARMS[g])
        ) u_reg (
            .clk   (CLK),
            .rst_n (rst_n),
            .bus   (bus)
        );
    end

    // receive-side detectors feeding the first info register
    assign zero_in  = !RX_LINE_POS_IN && !RX_LINE_NEG_IN;
    assign run_len  = {1'b0, st.zero_cnt} + 6'h01;
    assign new_pos  = {st.pos_h[6:0], RX_LINE_POS_IN};
    assign new_neg  = {st.neg_h[6:0], RX_LINE_NEG_IN};
    assign new_hist = {st.sef_hist[6:0], FBIT_ERR_IN} & SEF_MASK;
    // codeword 000VB0VB: violations share the polarity of the pulse before
    assign cw_hit   = st.last_pos ? (new_pos == `LSI_CW_VIOL && new_neg == `LSI_CW_BIP)
                                  : (new_neg == `LSI_CW_VIOL && new_pos == `LSI_CW_BIP);

    // summary: only interrupt-capable sources, each through its mask
    always_comb begin
        sum = 8'h00;
        sum[`LSI_SUM_A_PRI] = |(pend_v[REG_PRI] & st.primary_irq_mask);
        sum[`LSI_SUM_A_SEC] = |(pend_v[REG_SEC] & st.secondary_irq_mask);
        sum[`LSI_SUM_A_DL]  = PATH_A_DATALINK_REQUEST;
        sum[`LSI_SUM_B_PRI] = PATH_B_PRIMARY_REQUEST;
        sum[`LSI_SUM_B_SEC] = PATH_B_SECONDARY_REQUEST;
        sum[`LSI_SUM_B_DL]  = PATH_B_DATALINK_REQUEST;
        sum[`LSI_SUM_BERT]  = BERT_REQUEST;
    end

    // next state of detectors, masks, read data and pin
    always_comb begin
        next_st = st;
        rx1_set = 8'h00;
        // zero run counter saturates so long runs keep flagging
        if (RX_BIT_STB) begin
            next_st.pos_h = new_pos;
            next_st.neg_h = new_neg;
            if (st.pos_h[7]) begin
                next_st.last_pos = 1'b1;
            end else if (st.neg_h[7]) begin
                next_st.last_pos = 1'b0;
            end
            if (zero_in) begin
                if (st.zero_cnt != `LSI_ZERO_SAT) begin
                    next_st.zero_cnt = run_len[4:0];
                end
                if (run_len >= 6'(ZERO_SHORT)) begin
                    rx1_set[`LSI_RX1_ZERO8] = 1'b1;
                end
                if (run_len >= 6'(ZERO_LONG)) begin
                    rx1_set[`LSI_RX1_ZERO16] = 1'b1;
                end
            end else begin
                next_st.zero_cnt = 5'h00;
            end
            // seen regardless of the coding selected for the line
            if (cw_hit) begin
                rx1_set[`LSI_RX1_CODEWORD] = 1'b1;
            end
        end
        // framing errors over a sliding window of framing bits
        if (FBIT_STB) begin
            next_st.sef_hist = new_hist;
            if (FBIT_ERR_IN) begin
                rx1_set[`LSI_RX1_FBIT] = 1'b1;
            end
            if ($countones(new_hist) >= SEF_ERRS) begin
                rx1_set[`LSI_RX1_SEVERE] = 1'b1;
            end
        end
        // compare new alignment with the one before the resync
        if (RESYNC_DONE) begin
            next_st.align_prev = ALIGN_POS;
            if (ALIGN_POS != st.align_prev) begin
                rx1_set[`LSI_RX1_ALIGN] = 1'b1;
            end
        end
        // mask registers, bit set means source enabled
        if (WR_STB && ADDR == `LSI_ADR_PRI_MASK) begin
            next_st.primary_irq_mask = WDATA;
        end
        if (WR_STB && ADDR == `LSI_ADR_SEC_MASK) begin
            next_st.secondary_irq_mask = WDATA;
        end
        // read data holds until the next read; unmapped reads give zero
        if (RD_STB) begin
            case (ADDR)
                `LSI_ADR_SUMMARY:  next_st.rdata = sum;
                `LSI_ADR_PRI_STAT: next_st.rdata = shown_v[REG_PRI];
                `LSI_ADR_SEC_STAT: next_st.rdata = shown_v[REG_SEC];
                `LSI_ADR_RX_ONE:   next_st.rdata = shown_v[REG_RX1];
                `LSI_ADR_RX_TWO:   next_st.rdata = shown_v[REG_RX2];
                `LSI_ADR_RX_THREE: next_st.rdata = shown_v[REG_RX3];
                `LSI_ADR_PRI_MASK: next_st.rdata = st.primary_irq_mask;
                `LSI_ADR_SEC_MASK: next_st.rdata = st.secondary_irq_mask;
                default:           next_st.rdata = `LSI_BYTE_RESET;
            endcase
        end
        // pin pulled low while any summary bit is pending
        next_st.int_oe_n = (sum == 8'h00);
        next_st.int_out  = 1'b0;
    end

    // registers start defined even though the host reprograms them
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.int_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA    = st.rdata;
    assign INT_OUT  = st.int_out;
    assign INT_OE_N = st.int_oe_n;

    default clocking d_clk @(posedge CLK);
    endclocking
    default disable iff (!rst_n);

    a_pin_follows: assert property (
        1'b1 |=> (INT_OE_N == ($past(sum) == 8'h00)))
        else $error("interrupt pin disagrees with summary");
    a_mask_gates: assert property (
        (st.primary_irq_mask == 8'h00 && st.secondary_irq_mask == 8'h00 && !PATH_A_DATALINK_REQUEST && !PATH_B_PRIMARY_REQUEST
            && !PATH_B_SECONDARY_REQUEST && !PATH_B_DATALINK_REQUEST && !BERT_REQUEST) |-> sum == 8'h00)
        else $error("masked source reached the summary");
    // receive info pending while every interrupt source is quiet must leave the pin released
    a_rx_silent: assert property (
        ((pend_v[REG_RX1] | pend_v[REG_RX2] | pend_v[REG_RX3]) != 8'h00
            && (pend_v[REG_PRI] & st.primary_irq_mask) == 8'h00 && (pend_v[REG_SEC] & st.secondary_irq_mask) == 8'h00
            && !PATH_A_DATALINK_REQUEST && !PATH_B_PRIMARY_REQUEST && !PATH_B_SECONDARY_REQUEST
            && !PATH_B_DATALINK_REQUEST && !BERT_REQUEST) |=> INT_OE_N)
        else $error("receive info drove the interrupt");
    a_alarm_edge: assert property (
        ((PRI_ALARM ^ $past(PRI_ALARM)) & st.primary_irq_mask[4:0] & ~$past(PRI_ALARM ^ $past(PRI_ALARM))) != 5'h00
            && !RD_STB |-> ##2 !INT_OE_N)
        else $error("alarm change gave no interrupt");
    a_zero_run: assert property (
        (RX_BIT_STB && zero_in && st.zero_cnt == 5'(ZERO_SHORT - 1)) |=> pend_v[REG_RX1][`LSI_RX1_ZERO8])
        else $error("eight zero run not flagged");
    a_sef_pair: assert property (
        (FBIT_STB && FBIT_ERR_IN && st.sef_hist[0]) |=> pend_v[REG_RX1][`LSI_RX1_SEVERE])
        else $error("two framing errors not flagged");
    a_align_flag: assert property (
        (RESYNC_DONE && ALIGN_POS != st.align_prev) |=> pend_v[REG_RX1][`LSI_RX1_ALIGN])
        else $error("alignment change not flagged");
    a_summary_read: assert property (
        (RD_STB && ADDR == `LSI_ADR_SUMMARY) |=> (RDATA == $past(sum)))
        else $error("summary read wrong");

    c_int_low: cover property (!INT_OE_N ##1 INT_OE_N);
    c_codeword: cover property (RX_BIT_STB && cw_hit);
    c_sixteen: cover property (rx1_set[`LSI_RX1_ZERO16]);
endmodule : lsi_top

// File: lsi_params.svh
// register map, bit positions, masks and counts of the status block
`ifndef LSI_PARAMS_SVH
`define LSI_PARAMS_SVH
// control port offsets
`define LSI_ADR_SUMMARY  8'h0E
`define LSI_ADR_RX_THREE 8'h10
`define LSI_ADR_PRI_MASK 8'h16
`define LSI_ADR_SEC_MASK 8'h17
`define LSI_ADR_PRI_STAT 8'h20
`define LSI_ADR_SEC_STAT 8'h21
`define LSI_ADR_RX_ONE   8'h22
`define LSI_ADR_RX_TWO   8'h31
// bits that follow an alarm level rather than an event pulse
`define LSI_ALARM_PRI    8'h1F
`define LSI_ALARM_NONE   8'h00
`define LSI_RX3_CARRIER  3
// receive info one positions
`define LSI_RX1_ALIGN    7
`define LSI_RX1_ZERO8    6
`define LSI_RX1_ZERO16   5
`define LSI_RX1_SEVERE   2
`define LSI_RX1_CODEWORD 1
`define LSI_RX1_FBIT     0
// interrupt summary positions
`define LSI_SUM_BERT     6
`define LSI_SUM_B_DL     5
`define LSI_SUM_B_SEC    4
`define LSI_SUM_B_PRI    3
`define LSI_SUM_A_DL     2
`define LSI_SUM_A_SEC    1
`define LSI_SUM_A_PRI    0
// detector figures and reset values
`define LSI_ZERO8_RUN    8
`define LSI_ZERO16_RUN   16
`define LSI_ZERO_SAT     5'h1F
`define LSI_SEF_WINDOW   6
`define LSI_SEF_LIMIT    2
`define LSI_CW_VIOL      8'h11
`define LSI_CW_BIP       8'h0A
`define LSI_BYTE_RESET   8'h00
`endif

// File: lsi_pkg.sv
// types shared by the status block modules
package lsi_pkg;
    typedef logic [7:0] lsi_byte_t;

    // index of the latched registers of one framer path
    typedef enum logic [2:0] {
        REG_PRI = 3'b000,
        REG_SEC = 3'b001,
        REG_RX1 = 3'b010,
        REG_RX2 = 3'b011,
        REG_RX3 = 3'b100
    } lsi_reg_e;

    // state of one latched status register
    typedef struct packed {
        lsi_byte_t latch;
        lsi_byte_t shown;
        lsi_byte_t prev;
        lsi_byte_t chg;
    } lsi_latch_s;

    // state of the top module
    typedef struct packed {
        lsi_byte_t  primary_irq_mask;
        lsi_byte_t  secondary_irq_mask;
        logic [4:0] zero_cnt;
        lsi_byte_t  sef_hist;
        lsi_byte_t  pos_h;
        lsi_byte_t  neg_h;
        logic       last_pos;
        lsi_byte_t  align_prev;
        lsi_byte_t  rdata;
        logic       int_oe_n;
        logic       int_out;
    } lsi_top_s;
endpackage : lsi_pkg

// File: lsi_stat_if.sv
// link between the top and one latched status register
interface lsi_stat_if;
    import lsi_pkg::*;
    lsi_byte_t set;
    lsi_byte_t level;
    logic      wr;
    logic      rd;
    lsi_byte_t wdata;
    lsi_byte_t shown;
    lsi_byte_t pend;
    modport top (output set, output level, output wr, output rd, output wdata, input shown, input pend);
    modport reg_side (input set, input level, input wr, input rd, input wdata, output shown, output pend);
endinterface : lsi_stat_if

// File: lsi_latch_reg.sv
// one latched status register with write-mask readable copy
`include "lsi_params.svh"
module lsi_latch_reg #(
    parameter lsi_pkg::lsi_byte_t ALARM = `LSI_ALARM_NONE
) (
    // clock and synchronised reset
    input wire logic    clk,
    input wire logic    rst_n,
    // host side and sources
    lsi_stat_if.reg_side bus
);
    import lsi_pkg::*;

    lsi_latch_s st;
    lsi_latch_s next_st;
    lsi_byte_t  evt_set;
    lsi_byte_t  alarm_lvl;
    lsi_byte_t  clr_ok;

    assign evt_set   = bus.set & ~ALARM;
    assign alarm_lvl = bus.level & ALARM;
    // bits that a read may clear: shown, no new event, alarm gone
    assign clr_ok    = st.shown & ~evt_set & ~alarm_lvl;

    // clear on read first, then set, so a coincident event survives
    always_comb begin
        next_st = st;
        for (int i = 0; i < 8; i++) begin
            if (bus.rd && st.shown[i]) begin
                next_st.latch[i] = 1'b0;
                next_st.chg[i]   = 1'b0;
            end
            if (ALARM[i]) begin
                if (bus.level[i]) begin
                    next_st.latch[i] = 1'b1;
                end
                if (bus.level[i] != st.prev[i]) begin
                    next_st.chg[i] = 1'b1;
                end
            end else if (bus.set[i]) begin
                next_st.latch[i] = 1'b1;
            end
            if (bus.wr && bus.wdata[i]) begin
                next_st.shown[i] = st.latch[i];
            end
        end
        next_st.prev = bus.level & ALARM;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // alarms request on change, events while latched
    assign bus.shown = st.shown;
    assign bus.pend  = (st.chg & ALARM) | (st.latch & ~ALARM);

    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        (bus.rd && evt_set != 8'h00) |=> ((st.latch & $past(evt_set)) == $past(evt_set)))
        else $error("event lost against a clearing read");
    a_alarm_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (alarm_lvl != 8'h00) |=> ((st.latch & $past(alarm_lvl)) == $past(alarm_lvl)))
        else $error("present alarm bit was cleared");
    a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
        bus.rd |=> ((st.latch & $past(clr_ok)) == 8'h00))
        else $error("read bit was not cleared");
    a_write_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (((st.shown ^ $past(st.shown)) & ~($past(bus.wdata) & {8{$past(bus.wr)}})) == 8'h00))
        else $error("readable copy changed at an unwritten position");
    c_read_clear: cover property (@(posedge clk) disable iff (!rst_n)
        bus.rd && (st.shown & st.latch) != 8'h00);
endmodule : lsi_latch_reg

// File: lsi_host_model.sv
// host processor model driving the control port of the status block
`include "lsi_params.svh"
module lsi_host_model (
    // clock
    input wire logic          clk,
    // control port
    output logic [7:0]        addr,
    output lsi_pkg::lsi_byte_t wdata,
    output logic              wr_stb,
    output logic              rd_stb,
    input wire lsi_pkg::lsi_byte_t rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import lsi_pkg::*;

    // idle port at time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // one write; idle lines show the inverse so stale data never looks live
    task automatic wr(input logic [7:0] a, input lsi_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : wr

    // one read; data is taken once the answering edge has landed
    task automatic rd(input logic [7:0] a, output lsi_byte_t d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : rd

    // write mask, read, write back masked result so late events are not lost
    task automatic poll(input logic [7:0] a, input lsi_byte_t m);
        lsi_byte_t d;
        wr(a, m);
        rd(a, d);
        wr(a, d & m);
    endtask : poll

    // contents are zero after reset, yet every register is written once
    task automatic init();
        wr(`LSI_ADR_PRI_MASK, 8'h00);
        wr(`LSI_ADR_SEC_MASK, 8'h00);
        wr(`LSI_ADR_PRI_STAT, 8'hFF);
        wr(`LSI_ADR_SEC_STAT, 8'hFF);
        wr(`LSI_ADR_RX_ONE, 8'hFF);
        wr(`LSI_ADR_RX_TWO, 8'hFF);
        wr(`LSI_ADR_RX_THREE, 8'hFF);
    endtask : init
endmodule : lsi_host_model

// File: latched_status_irq_logic_tb.sv
// self-checking testbench of the latched status and interrupt block
`include "lsi_params.svh"
module latched_status_irq_logic_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lsi_pkg::*;

    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr;
    lsi_byte_t  wdata, rdata, sec_ev, rx2_ev, align, m;
    logic       wr_stb, rd_stb, bit_stb, pos, neg, fb_stb, fb_err, resync;
    logic       int_out, int_oe_n;
    logic       rd_pend = 1'b0;
    logic [4:0] alarm, req;
    logic [1:0] cw [9] = '{2'b10, 2'b00, 2'b00, 2'b00, 2'b10, 2'b01, 2'b00, 2'b01, 2'b10};
    int         failures = 0;
    int         check_count = 0;
    int         seed = 33326;
    int         r;
    lsi_byte_t  exp_q[$];

    // 40 MHz clock
    always #12.5 clk = ~clk;

    lsi_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

    lsi_top uut (
        .CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .PRI_ALARM(alarm), .PRI_EVENT(3'h0), .SEC_EVENT(sec_ev), .RX2_EVENT(rx2_ev), .RX3_EVENT(8'h00),
        .RX3_CARRIER_LOSS(1'b0), .RX_BIT_STB(bit_stb), .RX_LINE_POS_IN(pos), .RX_LINE_NEG_IN(neg),
        .FBIT_STB(fb_stb), .FBIT_ERR_IN(fb_err), .RESYNC_DONE(resync), .ALIGN_POS(align),
        .PATH_A_DATALINK_REQUEST(req[0]), .PATH_B_PRIMARY_REQUEST(req[1]), .PATH_B_SECONDARY_REQUEST(req[2]),
        .PATH_B_DATALINK_REQUEST(req[3]), .BERT_REQUEST(req[4]), .INT_OUT(int_out), .INT_OE_N(int_oe_n));

    task automatic check(input lsi_byte_t seen, input lsi_byte_t exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    // pin level two edges on, the latency of latch plus output flop
    task automatic pin(input logic e);
        repeat (2) @(posedge clk);
        #1;
        check({6'h00, int_out, int_oe_n}, {7'h00, e});
    endtask : pin

    task automatic poll(input logic [7:0] a, input lsi_byte_t mk, input lsi_byte_t e);
        exp_q.push_back(e);
        host.poll(a, mk);
    endtask : poll

    task automatic sumrd(input lsi_byte_t e);
        lsi_byte_t d;
        exp_q.push_back(e);
        host.rd(`LSI_ADR_SUMMARY, d);
    endtask : sumrd

    task automatic evt(input lsi_byte_t s, input lsi_byte_t x);
        @(posedge clk);
        sec_ev <= s;
        rx2_ev <= x;
        @(posedge clk);
        sec_ev <= 8'h00;
        rx2_ev <= 8'h00;
    endtask : evt

    task automatic lbit(input logic p, input logic n);
        @(posedge clk);
        bit_stb <= 1'b1;
        pos <= p;
        neg <= n;
        @(posedge clk);
        bit_stb <= 1'b0;
    endtask : lbit

    task automatic fbit(input logic e);
        @(posedge clk);
        fb_stb <= 1'b1;
        fb_err <= e;
        @(posedge clk);
        fb_stb <= 1'b0;
    endtask : fbit

    task automatic sync(input lsi_byte_t a);
        @(posedge clk);
        resync <= 1'b1;
        align <= a;
        @(posedge clk);
        resync <= 1'b0;
    endtask : sync

    // read monitor: the answer stands one cycle after the strobe edge
    always @(posedge clk) begin
        if (rd_pend) begin
            check(rdata, exp_q.pop_front());
        end
        rd_pend <= rd_stb;
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end

    // main sequence
    initial begin
        {sec_ev, rx2_ev, align, alarm, req} = '0;
        {bit_stb, pos, neg, fb_stb, fb_err, resync} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({6'h00, int_out, int_oe_n}, 8'h01);
        host.init();
        sumrd(8'h00);
        $display("test reset finished");
        host.wr(`LSI_ADR_SEC_MASK, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            m = 8'h01 << r[2:0];
            evt(m, 8'h00);
            pin(1'b0);
            sumrd(8'h02);
            poll(`LSI_ADR_SEC_STAT, m, m);
            pin(1'b1);
            poll(`LSI_ADR_SEC_STAT, m, 8'h00);
        end
        evt(8'h06, 8'h00);
        poll(`LSI_ADR_SEC_STAT, 8'h02, 8'h02);
        poll(`LSI_ADR_SEC_STAT, 8'h04, 8'h04);
        pin(1'b1);
        host.wr(`LSI_ADR_SEC_MASK, 8'hFE);
        evt(8'h01, 8'hFF);
        pin(1'b1);
        poll(`LSI_ADR_SEC_STAT, 8'h01, 8'h01);
        $display("test events finished");
        host.wr(`LSI_ADR_PRI_MASK, 8'h01);
        @(posedge clk);
        alarm <= 5'h01;
        @(posedge clk);
        pin(1'b0);
        poll(`LSI_ADR_PRI_STAT, 8'h01, 8'h01);
        pin(1'b1);
        poll(`LSI_ADR_PRI_STAT, 8'h01, 8'h01);
        @(posedge clk);
        alarm <= 5'h00;
        @(posedge clk);
        pin(1'b0);
        poll(`LSI_ADR_PRI_STAT, 8'h01, 8'h01);
        pin(1'b1);
        poll(`LSI_ADR_PRI_STAT, 8'h01, 8'h00);
        $display("test alarms finished");
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            req <= 5'h01 << k;
            pin(1'b0);
            sumrd(8'h04 << k);
        end
        @(posedge clk);
        req <= 5'h00;
        pin(1'b1);
        $display("test summary finished");
        repeat (7) lbit(1'b0, 1'b0);
        lbit(1'b1, 1'b0);
        poll(`LSI_ADR_RX_ONE, 8'h60, 8'h00);
        repeat (8) lbit(1'b0, 1'b0);
        lbit(1'b1, 1'b0);
        poll(`LSI_ADR_RX_ONE, 8'h60, 8'h40);
        repeat (20) lbit(1'b0, 1'b0);
        poll(`LSI_ADR_RX_ONE, 8'h60, 8'h60);
        pin(1'b1);
        foreach (cw[i]) lbit(cw[i][1], cw[i][0]);
        poll(`LSI_ADR_RX_ONE, 8'h02, 8'h02);
        fbit(1'b1);
        repeat (5) fbit(1'b0);
        fbit(1'b1);
        poll(`LSI_ADR_RX_ONE, 8'h05, 8'h01);
        fbit(1'b1);
        poll(`LSI_ADR_RX_ONE, 8'h05, 8'h05);
        sync(8'h05);
        poll(`LSI_ADR_RX_ONE, 8'h80, 8'h80);
        sync(8'h05);
        poll(`LSI_ADR_RX_ONE, 8'h80, 8'h00);
        $display("test detectors finished");
        complete_run();
    end
endmodule : latched_status_irq_logic_tb
